/* hdiap_top.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Interrupt line is pulled low while any unmasked interrupt cause is pending.
// - Interrupt output is open drain: it pulls low or floats, never drives high.
// - Acknowledge with read strobe on a receive request returns the receive FIFO head.
// - Acknowledge with write strobe on a transmit request writes into the transmit FIFO.
// - While an acknowledge is active the address inputs are ignored.
// - Alternate clock pin level is readable as a general or carrier-detect input.
// - With auto-start set, the alternate clock pin enables the receiver.
// - In clock mode 1 the alternate clock pin is the receive strobe.
// - In clock mode 5 the alternate clock pin is the frame sync input.
// - In modes 4, 6, 7 channel A's pin is a crystal pin, not logic.
// - Receive request holds for a whole block and drops right after the last read.
module hdiap_top (
	input  wire logic                                               CORE_CLK,
	input  wire logic                                               RST_N,
	input  wire logic                                               RD_N,
	input  wire logic                                               WR_N,
	input  wire logic                                               DMA_ACK_CH_A_N,
	input  wire logic                                               DMA_ACK_CH_B_N,
	input  wire logic [hdiap_pkg::ADDR_W-1:0]                       ADDR,
	input  wire logic [hdiap_pkg::DATA_W-1:0]                       DATA_IN,
	output logic      [hdiap_pkg::DATA_W-1:0]                       DATA_OUT,
	output logic                                                    DATA_OE_N,
	output logic                                                    REG_RD_STB,
	output logic                                                    REG_WR_STB,
	output logic      [hdiap_pkg::ADDR_W-1:0]                       REG_ADDR,
	output logic      [hdiap_pkg::DATA_W-1:0]                       REG_WDATA,
	input  wire logic [hdiap_pkg::IRQ_W-1:0]                        IRQ_EVENT,
	input  wire logic [hdiap_pkg::IRQ_W-1:0]                        IRQ_MASK,
	input  wire logic [hdiap_pkg::IRQ_W-1:0]                        IRQ_CLEAR,
	output logic      [hdiap_pkg::IRQ_W-1:0]                        IRQ_STATUS,
	output logic                                                    INT_N_O,
	output logic                                                    INT_N_OE_N,
	input  wire logic [hdiap_pkg::CHANNELS-1:0]                     RX_IN_VALID,
	input  wire logic [hdiap_pkg::CHANNELS-1:0][hdiap_pkg::DATA_W-1:0] RX_IN_DATA,
	output logic      [hdiap_pkg::CHANNELS-1:0]                     RX_IN_READY,
	output logic      [hdiap_pkg::CHANNELS-1:0]                     RX_DMA_REQUEST,
	output logic      [hdiap_pkg::CHANNELS-1:0]                     TX_OUT_VALID,
	output logic      [hdiap_pkg::CHANNELS-1:0][hdiap_pkg::DATA_W-1:0] TX_OUT_DATA,
	input  wire logic [hdiap_pkg::CHANNELS-1:0]                     TX_OUT_READY,
	output logic      [hdiap_pkg::CHANNELS-1:0]                     TX_DMA_REQUEST,
	input  wire logic [hdiap_pkg::CHANNELS-1:0]                     ALT_CLK_IN,
	input  wire logic [hdiap_pkg::CHANNELS-1:0][hdiap_pkg::MODE_W-1:0] CLK_MODE,
	input  wire logic [hdiap_pkg::CHANNELS-1:0]                     AUTO_START,
	output logic      [hdiap_pkg::CHANNELS-1:0]                     ALT_LEVEL,
	output logic      [hdiap_pkg::CHANNELS-1:0]                     RX_ENABLE,
	output logic      [hdiap_pkg::CHANNELS-1:0]                     RX_STROBE,
	output logic      [hdiap_pkg::CHANNELS-1:0]                     FRAME_SYNC,
	output logic                                                    OSC_XTAL_A
);

	localparam int NCH = hdiap_pkg::CHANNELS;
	localparam int DW  = hdiap_pkg::DATA_W;
	localparam int CW  = hdiap_pkg::CNT_W;

	logic [hdiap_pkg::SY_W-1:0]   sy1_q;
	logic [hdiap_pkg::SY_W-1:0]   sy2_q;
	logic                         rd_prev_q;
	logic                         wr_prev_q;
	logic [NCH-1:0]               alt_prev_q;
	logic                         rd_n_s;
	logic                         wr_n_s;
	logic [NCH-1:0]               alt_s;
	logic [hdiap_pkg::ADDR_W-1:0] addr_s;
	logic [DW-1:0]                din_s;
	logic                         rd_fall;
	logic                         wr_fall;
	logic [NCH-1:0]               dack_act;
	logic                         any_dack;
	logic [NCH-1:0]               dack_sel;
	logic [NCH-1:0]               rx_pop;
	logic [NCH-1:0]               tx_push;
	logic [NCH-1:0][DW-1:0]       rx_head;
	logic [NCH-1:0]               rx_head_vld;
	logic [NCH-1:0][CW-1:0]       rx_level;
	logic [NCH-1:0][CW-1:0]       tx_level;
	logic [NCH-1:0]               tx_in_ready;
	logic [NCH-1:0]               rx_req_q;
	logic [NCH-1:0]               tx_req_q;
	logic [NCH-1:0][CW-1:0]       rx_left_q;
	logic [NCH-1:0][CW-1:0]       tx_left_q;
	logic [NCH-1:0]               xtal;
	logic [NCH-1:0]               alt_lvl;
	logic [DW-1:0]                dout_q;
	logic                         dout_oe_n_q;
	logic                         reg_rd_q;
	logic                         reg_wr_q;
	logic [hdiap_pkg::ADDR_W-1:0] reg_addr_q;
	logic [DW-1:0]                reg_wdata_q;
	logic [hdiap_pkg::IRQ_W-1:0]  pend_q;
	logic [hdiap_pkg::IRQ_W-1:0]  pend_d;
	logic                         irq_live_d;
	logic                         int_oe_n_q;
	logic [NCH-1:0]               alt_level_q;
	logic [NCH-1:0]               rx_en_q;
	logic [NCH-1:0]               rx_stb_q;
	logic [NCH-1:0]               fsync_q;
	logic                         xtal_a_q;

	// Every host bus and alternate clock pin passes two flops; only the second stage feeds any logic.
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sy1_q <= hdiap_pkg::SY_RST;
			sy2_q <= hdiap_pkg::SY_RST;
		end
		else
		begin
			sy1_q <= {RD_N, WR_N, DMA_ACK_CH_B_N, DMA_ACK_CH_A_N, ALT_CLK_IN, ADDR, DATA_IN};
			sy2_q <= sy1_q;
		end
	end

	// Field split of the synchronised pins. Data and address ride the same two
	// stages as the strobes, so they line up with the strobe edge they belong to.
	assign rd_n_s   = sy2_q[hdiap_pkg::SY_RD];
	assign wr_n_s   = sy2_q[hdiap_pkg::SY_WR];
	assign alt_s    = sy2_q[hdiap_pkg::SY_ALT +: NCH];
	assign addr_s   = sy2_q[hdiap_pkg::SY_ADDR +: hdiap_pkg::ADDR_W];
	assign din_s    = sy2_q[hdiap_pkg::SY_DATA +: DW];
	assign dack_act = ~{sy2_q[hdiap_pkg::SY_ACKB], sy2_q[hdiap_pkg::SY_ACKA]};
	assign any_dack = |dack_act;
	assign rd_fall  = rd_prev_q & ~rd_n_s;
	assign wr_fall  = wr_prev_q & ~wr_n_s;

	// Channel A wins if the DMA controller wrongly acknowledges both at once.
	assign dack_sel = dack_act[hdiap_pkg::CH_A] ? 2'h1 : dack_act;

	// Plain register cycles only when no acknowledge is active.
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rd_prev_q   <= 1'b1;
			wr_prev_q   <= 1'b1;
			alt_prev_q  <= '0;
			reg_rd_q    <= 1'b0;
			reg_wr_q    <= 1'b0;
			reg_addr_q  <= hdiap_pkg::ADDR_RST;
			reg_wdata_q <= hdiap_pkg::DATA_RST;
		end
		else
		begin
			rd_prev_q  <= rd_n_s;
			wr_prev_q  <= wr_n_s;
			alt_prev_q <= alt_s;
			reg_rd_q   <= rd_fall & ~any_dack;
			reg_wr_q   <= wr_fall & ~any_dack;
			if ((rd_fall | wr_fall) & ~any_dack)
			begin
				reg_addr_q  <= addr_s;
				reg_wdata_q <= din_s;
			end
		end
	end

	// Read data drives the bus from the DMA read until the strobe rises again.
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			dout_q      <= hdiap_pkg::DATA_RST;
			dout_oe_n_q <= 1'b1;
		end
		else
		begin
			if (|rx_pop)
			begin
				dout_q      <= rx_pop[hdiap_pkg::CH_A] ? rx_head[hdiap_pkg::CH_A]
				                                       : rx_head[hdiap_pkg::CH_B];
				dout_oe_n_q <= 1'b0;
			end
			else if (rd_n_s)
				dout_oe_n_q <= 1'b1;
		end
	end

	// Interrupt sources: a new event beats a clear in the same cycle.
	assign pend_d     = (pend_q & ~IRQ_CLEAR) | IRQ_EVENT;
	assign irq_live_d = |(pend_d & ~IRQ_MASK);

	// The pin is released only when nothing unmasked is left pending.
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pend_q     <= hdiap_pkg::IRQ_RST;
			int_oe_n_q <= 1'b1;
		end
		else
		begin
			pend_q     <= pend_d;
			int_oe_n_q <= ~irq_live_d;
		end
	end

	// The driven level is always low; high comes from the board pull-up only.
	assign INT_N_O = 1'b0;

	// Per channel: FIFOs, DMA request bursts and the alternate clock pin.
	for (genvar ch = 0; ch < NCH; ch++)
	begin : g_ch
		assign rx_pop[ch]  = rd_fall & dack_sel[ch] & rx_req_q[ch] & rx_head_vld[ch];
		assign tx_push[ch] = wr_fall & dack_sel[ch] & tx_req_q[ch] & tx_in_ready[ch];
		assign xtal[ch]    = (ch == hdiap_pkg::CH_A) &&
		                     (CLK_MODE[ch] == hdiap_pkg::CM_XTAL4 ||
		                      CLK_MODE[ch] == hdiap_pkg::CM_XTAL6 ||
		                      CLK_MODE[ch] == hdiap_pkg::CM_XTAL7);
		assign alt_lvl[ch] = alt_s[ch] & ~xtal[ch];

		// Receive data waits here until the DMA controller takes a block.
		hdiap_fifo #(.W(DW), .D(hdiap_pkg::FIFO_DEPTH)) u_rx (
			.clk       (CORE_CLK),
			.rst_n     (RST_N),
			.in_valid  (RX_IN_VALID[ch]),
			.in_data   (RX_IN_DATA[ch]),
			.in_ready  (RX_IN_READY[ch]),
			.out_valid (rx_head_vld[ch]),
			.out_data  (rx_head[ch]),
			.out_ready (rx_pop[ch]),
			.level     (rx_level[ch])
		);

		// Transmit bytes from the DMA controller wait for the serial side.
		hdiap_fifo #(.W(DW), .D(hdiap_pkg::FIFO_DEPTH)) u_tx (
			.clk       (CORE_CLK),
			.rst_n     (RST_N),
			.in_valid  (tx_push[ch]),
			.in_data   (din_s),
			.in_ready  (tx_in_ready[ch]),
			.out_valid (TX_OUT_VALID[ch]),
			.out_data  (TX_OUT_DATA[ch]),
			.out_ready (TX_OUT_READY[ch]),
			.level     (tx_level[ch])
		);

		// A request spans one block and drops after the read or write that ends it.
		always_ff @(posedge CORE_CLK or negedge RST_N)
		begin
			if (!RST_N)
			begin
				rx_req_q[ch]  <= 1'b0;
				rx_left_q[ch] <= hdiap_pkg::CNT_RST;
				tx_req_q[ch]  <= 1'b0;
				tx_left_q[ch] <= hdiap_pkg::CNT_RST;
			end
			else
			begin
				if (!rx_req_q[ch] && rx_level[ch] >= hdiap_pkg::BLOCK_BYTES)
				begin
					rx_req_q[ch]  <= 1'b1;
					rx_left_q[ch] <= hdiap_pkg::BLOCK_BYTES;
				end
				else if (rx_pop[ch])
				begin
					rx_left_q[ch] <= CW'(rx_left_q[ch] - 1'b1);
					if (rx_left_q[ch] == hdiap_pkg::LAST_BYTE)
						rx_req_q[ch] <= 1'b0;
				end
				if (!tx_req_q[ch] && tx_level[ch] == hdiap_pkg::CNT_RST)
				begin
					tx_req_q[ch]  <= 1'b1;
					tx_left_q[ch] <= hdiap_pkg::BLOCK_BYTES;
				end
				else if (tx_push[ch])
				begin
					tx_left_q[ch] <= CW'(tx_left_q[ch] - 1'b1);
					if (tx_left_q[ch] == hdiap_pkg::LAST_BYTE)
						tx_req_q[ch] <= 1'b0;
				end
			end
		end

		// The alternate clock pin's meaning follows the clock mode.
		always_ff @(posedge CORE_CLK or negedge RST_N)
		begin
			if (!RST_N)
			begin
				alt_level_q[ch] <= 1'b0;
				rx_en_q[ch]     <= 1'b0;
				rx_stb_q[ch]    <= 1'b0;
				fsync_q[ch]     <= 1'b0;
			end
			else
			begin
				alt_level_q[ch] <= alt_lvl[ch];
				rx_en_q[ch]     <= ~AUTO_START[ch] | alt_lvl[ch];
				rx_stb_q[ch]    <= (CLK_MODE[ch] == hdiap_pkg::CM_STROBE) & alt_lvl[ch];
				fsync_q[ch]     <= (CLK_MODE[ch] == hdiap_pkg::CM_FSYNC) &
				                   alt_lvl[ch] & ~alt_prev_q[ch];
			end
		end
	end

	// Crystal selection for channel A's oscillator pins.
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			xtal_a_q <= 1'b0;
		else
			xtal_a_q <= xtal[hdiap_pkg::CH_A];
	end

	// Output wiring, all from registers except the FIFO faces and the constant pin.
	assign DATA_OUT       = dout_q;
	assign DATA_OE_N      = dout_oe_n_q;
	assign REG_RD_STB     = reg_rd_q;
	assign REG_WR_STB     = reg_wr_q;
	assign REG_ADDR       = reg_addr_q;
	assign REG_WDATA      = reg_wdata_q;
	assign IRQ_STATUS     = pend_q;
	assign INT_N_OE_N     = int_oe_n_q;
	assign RX_DMA_REQUEST = rx_req_q;
	assign TX_DMA_REQUEST = tx_req_q;
	assign ALT_LEVEL      = alt_level_q;
	assign RX_ENABLE      = rx_en_q;
	assign RX_STROBE      = rx_stb_q;
	assign FRAME_SYNC     = fsync_q;
	assign OSC_XTAL_A     = xtal_a_q;

	// Checks on the behaviour above.
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_rx_start;
		!rx_req_q[0] ##1 rx_req_q[0];
	endsequence

	sequence s_alt_b_high;
		ALT_CLK_IN[1] [*4];
	endsequence

	a_int_pull_low: assert property (irq_live_d |=> !INT_N_OE_N)
		else $error("interrupt not pulled low while a cause is pending");
	a_int_never_high: assert property (INT_N_O == 1'b0)
		else $error("interrupt pin driven high");
	a_int_release: assert property (!irq_live_d |=> INT_N_OE_N)
		else $error("interrupt still driven after causes cleared");
	a_rx_pop_data: assert property (rx_pop[0] |=> !DATA_OE_N && DATA_OUT == $past(rx_head[0]))
		else $error("DMA read did not return the receive FIFO head");
	a_tx_push_ok: assert property (tx_push[0] && !TX_OUT_READY[0] |=>
		tx_level[0] == $past(tx_level[0]) + 3'h1)
		else $error("DMA write did not land in the transmit FIFO");
	a_addr_ignored: assert property (any_dack && (rd_fall || wr_fall) |=> !REG_RD_STB && !REG_WR_STB)
		else $error("register access during DMA acknowledge");
	a_alt_level_b: assert property (s_alt_b_high |=> ALT_LEVEL[1])
		else $error("alternate pin level not reflected");
	a_rx_gate_b: assert property (AUTO_START[1] && !alt_s[1] |=> !RX_ENABLE[1])
		else $error("receiver enabled while gate pin low");
	a_strobe_mode: assert property (RX_STROBE[0] |-> $past(CLK_MODE[0]) == hdiap_pkg::CM_STROBE)
		else $error("receive strobe outside strobe mode");
	a_fsync_mode: assert property (FRAME_SYNC[1] |-> $past(CLK_MODE[1]) == hdiap_pkg::CM_FSYNC)
		else $error("frame sync outside sync mode");
	a_xtal_mask: assert property (CLK_MODE[0] == hdiap_pkg::CM_XTAL6 |=> OSC_XTAL_A && !ALT_LEVEL[0])
		else $error("crystal pin used as logic input");
	a_rx_block: assert property (s_rx_start |-> rx_left_q[0] == hdiap_pkg::BLOCK_BYTES)
		else $error("receive request not sized to a block");
	a_rx_last_drop: assert property (rx_pop[0] && rx_left_q[0] == hdiap_pkg::LAST_BYTE |=>
		!RX_DMA_REQUEST[0])
		else $error("receive request held after last read");

endmodule

/* hdiap_pkg.sv */
package hdiap_pkg;

	// Geometry of the host port.
	localparam int CHANNELS   = 2;
	localparam int DATA_W     = 8;
	localparam int ADDR_W     = 7;
	localparam int IRQ_W      = 4;
	localparam int MODE_W     = 3;
	localparam int FIFO_DEPTH = 4;
	localparam int CNT_W      = 3;

	// Channel indices.
	localparam int CH_A = 0;
	localparam int CH_B = 1;

	// Bytes moved per DMA request burst; the FIFO holds exactly one burst.
	localparam logic [CNT_W-1:0] BLOCK_BYTES = 3'h4;
	localparam logic [CNT_W-1:0] LAST_BYTE   = 3'h1;
	localparam logic [CNT_W-1:0] CNT_RST     = 3'h0;

	// Clock mode encodings that change the alternate clock pin's meaning.
	localparam logic [MODE_W-1:0] CM_STROBE = 3'h1;
	localparam logic [MODE_W-1:0] CM_XTAL4  = 3'h4;
	localparam logic [MODE_W-1:0] CM_FSYNC  = 3'h5;
	localparam logic [MODE_W-1:0] CM_XTAL6  = 3'h6;
	localparam logic [MODE_W-1:0] CM_XTAL7  = 3'h7;

	// Synchroniser bit positions: {rd, wr, ack_b, ack_a, alt[1:0], addr, data}.
	localparam int SY_W    = 21;
	localparam int SY_RD   = 20;
	localparam int SY_WR   = 19;
	localparam int SY_ACKB = 18;
	localparam int SY_ACKA = 17;
	localparam int SY_ALT  = 15;
	localparam int SY_ADDR = 8;
	localparam int SY_DATA = 0;

	// Strobes and acknowledges rest high after reset, everything else low.
	localparam logic [SY_W-1:0] SY_RST = 21'h1E0000;

	// Reset values of the output registers.
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
	localparam logic [IRQ_W-1:0]  IRQ_RST  = 4'h0;

endpackage

/* hdiap_fifo.sv */
`timescale 1ns/1ps

module hdiap_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   in_valid,
	input  wire logic [W-1:0]           in_data,
	output logic                        in_ready,
	output logic                        out_valid,
	output logic [W-1:0]                out_data,
	input  wire logic                   out_ready,
	output logic [$clog2(D+1)-1:0]      level
);

	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D+1);

	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] cnt_q;
	logic          push;
	logic          pop;

	// A full FIFO refuses writes, which is what stalls the filling side.
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign in_ready  = (cnt_q != CW'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_ptr_q];
	assign level     = cnt_q;

	// Pointers wrap explicitly so any depth works, not only powers of two.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == AW'(D-1)) ? '0 : AW'(wr_ptr_q + 1'b1);
			if (pop)
				rd_ptr_q <= (rd_ptr_q == AW'(D-1)) ? '0 : AW'(rd_ptr_q + 1'b1);
			if (push & ~pop)
				cnt_q <= CW'(cnt_q + 1'b1);
			else if (pop & ~push)
				cnt_q <= CW'(cnt_q - 1'b1);
		end
	end

	// Storage has no reset; entries are only read once written.
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

endmodule

/* hdiap_host_model.sv */
`timescale 1ns/1ps

// Host CPU and DMA controller side of the parallel port, driven only at rising edges.
module hdiap_host_model (
	input  wire logic                         clk,
	output logic                              rd_n,
	output logic                              wr_n,
	output logic                              ack_a_n,
	output logic                              ack_b_n,
	output logic [hdiap_pkg::ADDR_W-1:0]      addr,
	output logic [hdiap_pkg::DATA_W-1:0]      data,
	input  wire logic [hdiap_pkg::DATA_W-1:0] rdata,
	input  wire logic                         oe_n
);
	// Unused acknowledges rest high; strobes idle high.
	initial
	begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		ack_a_n = 1'b1;
		ack_b_n = 1'b1;
		addr = 7'h00;
		data = 8'h00;
	end

	// One bus cycle; acknowledge goes low first, as the bus is already owned by then.
	task automatic cycle(input logic is_rd, input logic [1:0] ack_n, input logic [6:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic oe);
		@(posedge clk);
		ack_a_n <= ack_n[0];
		ack_b_n <= ack_n[1];
		addr <= a;
		data <= d;
		repeat (3) @(posedge clk);
		if (is_rd)
			rd_n <= 1'b0;
		else
			wr_n <= 1'b0;
		repeat (5) @(posedge clk);
		q = rdata;
		oe = oe_n;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		@(posedge clk);
		ack_a_n <= 1'b1;
		ack_b_n <= 1'b1;
		// Released lines show the inverse so a stale value is never mistaken for data.
		addr <= ~a;
		data <= ~d;
		repeat (4) @(posedge clk);
	endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
	logic clk, rst_n, rd_n, wr_n, ack_a_n, ack_b_n, dout_oe_n, reg_rd, reg_wr, int_o, int_oe_n, osc_a;
	logic [6:0] addr, reg_addr;
	logic [7:0] din, dout, reg_wdata, b, e;
	logic [3:0] irq_ev, irq_mask, irq_clr, irq_stat;
	logic [1:0] rx_vld, rx_rdy, rx_req, tx_vld, tx_rdy, tx_req, alt_in, auto_st;
	logic [1:0] alt_lvl, rx_en, rx_stb, fsync;
	logic [1:0][7:0] rx_data, tx_data;
	logic [1:0][2:0] mode;
	logic [31:0] seed_v = 32'h3D9EFFDC;
	logic [31:0] r;
	logic [2:0] md;
	logic oe, lv;
	logic [7:0] q[$];
	int error_cnt, tests_run, rd_pulses, wr_pulses, exp_rd, exp_wr, n, c, k, m;

	hdiap_top dut (.CORE_CLK(clk), .RST_N(rst_n), .RD_N(rd_n), .WR_N(wr_n),
		.DMA_ACK_CH_A_N(ack_a_n), .DMA_ACK_CH_B_N(ack_b_n), .ADDR(addr), .DATA_IN(din),
		.DATA_OUT(dout), .DATA_OE_N(dout_oe_n), .REG_RD_STB(reg_rd), .REG_WR_STB(reg_wr),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .IRQ_EVENT(irq_ev), .IRQ_MASK(irq_mask),
		.IRQ_CLEAR(irq_clr), .IRQ_STATUS(irq_stat), .INT_N_O(int_o), .INT_N_OE_N(int_oe_n),
		.RX_IN_VALID(rx_vld), .RX_IN_DATA(rx_data), .RX_IN_READY(rx_rdy),
		.RX_DMA_REQUEST(rx_req), .TX_OUT_VALID(tx_vld), .TX_OUT_DATA(tx_data),
		.TX_OUT_READY(tx_rdy), .TX_DMA_REQUEST(tx_req), .ALT_CLK_IN(alt_in), .CLK_MODE(mode),
		.AUTO_START(auto_st), .ALT_LEVEL(alt_lvl), .RX_ENABLE(rx_en), .RX_STROBE(rx_stb),
		.FRAME_SYNC(fsync), .OSC_XTAL_A(osc_a));

	hdiap_host_model host (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .ack_a_n(ack_a_n),
		.ack_b_n(ack_b_n), .addr(addr), .data(din), .rdata(dout), .oe_n(dout_oe_n));

	// Free-running 25 MHz clock.
	always #20 clk = ~clk;

	// Register strobes are counted so DMA cycles can be shown to raise none.
	always @(posedge clk)
	begin
		if (reg_rd === 1'b1)
			rd_pulses++;
		if (reg_wr === 1'b1)
			wr_pulses++;
	end

	// Pseudo-random source, fixed start so every run repeats.
	function automatic logic [31:0] rnd();
		seed_v = {seed_v[30:0], seed_v[31] ^ seed_v[21] ^ seed_v[1] ^ seed_v[0]};
		return seed_v;
	endfunction

	// Channel A loses its logic function in the crystal modes.
	function automatic logic xtal(input logic [2:0] md_v);
		return md_v == hdiap_pkg::CM_XTAL4 || md_v == hdiap_pkg::CM_XTAL6 ||
			md_v == hdiap_pkg::CM_XTAL7;
	endfunction

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic give_up();
		error_cnt++;
		final_report();
	endtask

	// Main sequence: reset, registers, receive and transmit DMA, interrupts, pin functions.
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		{irq_ev, irq_mask, irq_clr} = 12'h000;
		{rx_vld, tx_rdy, alt_in, auto_st} = 8'h00;
		rx_data = 16'h0000;
		mode = 6'h00;
		repeat (2) @(posedge clk);
		`CHK(dout_oe_n, 1'b1)
		`CHK(int_oe_n, 1'b1)
		rst_n <= 1'b1;
		for (n = 0; n < 10 && tx_req !== 2'h3; n++) @(posedge clk);
		`CHK(tx_req, 2'h3)
		if (n == 10) give_up();
		// Plain register cycles, random direction, address and data.
		for (k = 0; k < 6; k++)
		begin
			r = rnd();
			host.cycle(r[16], 2'h3, r[6:0], r[15:8], b, oe);
			if (r[16]) exp_rd++;
			else exp_wr++;
			`CHK(reg_addr, r[6:0])
			if (!r[16]) `CHK(reg_wdata, r[15:8])
		end
		// Receive DMA: fill until refused, then read one block through the acknowledge.
		for (c = 0; c < 2; c++)
		begin
			for (k = 0; k < 4; k++)
			begin
				r = rnd();
				b = (k == 0) ? 8'hFF : r[7:0];
				rx_data[c] <= b;
				rx_vld[c] <= 1'b1;
				q.push_back(b);
				for (n = 0; n < 50; n++)
				begin
					@(posedge clk);
					if (rx_rdy[c] === 1'b1) break;
				end
				if (n == 50) give_up();
			end
			rx_data[c] <= 8'h5A;
			repeat (3) @(posedge clk);
			`CHK(rx_rdy[c], 1'b0)
			rx_vld[c] <= 1'b0;
			for (n = 0; n < 50 && rx_req[c] !== 1'b1; n++) @(posedge clk);
			if (n == 50) give_up();
			for (k = 0; k < 4; k++)
			begin
				`CHK(rx_req[c], 1'b1)
				r = rnd();
				host.cycle(1'b1, c ? 2'h1 : 2'h2, r[6:0], r[15:8], b, oe);
				e = q.pop_front();
				`CHK(b, e)
				`CHK(oe, 1'b0)
			end
			`CHK(rx_req[c], 1'b0)
		end
		// A DMA read with no receive request pending must leave the data bus alone.
		host.cycle(1'b1, 2'h2, 7'h00, 8'h00, b, oe);
		`CHK(oe, 1'b1)
		// Transmit DMA with the core stalled, then drained.
		for (c = 0; c < 2; c++)
		begin
			for (k = 0; k < 4; k++)
			begin
				`CHK(tx_req[c], 1'b1)
				r = rnd();
				q.push_back(r[15:8]);
				host.cycle(1'b0, c ? 2'h1 : 2'h2, r[6:0], r[15:8], b, oe);
			end
			`CHK(tx_req[c], 1'b0)
			// A fifth write after the block has ended must be refused.
			host.cycle(1'b0, c ? 2'h1 : 2'h2, 7'h00, 8'hA5, b, oe);
			tx_rdy[c] <= 1'b1;
			for (n = 0; n < 40 && q.size() > 0; n++)
			begin
				@(posedge clk);
				if (tx_vld[c] === 1'b1)
				begin
					e = q.pop_front();
					`CHK(tx_data[c], e)
				end
			end
			if (q.size() > 0) give_up();
			@(posedge clk);
			`CHK(tx_vld[c], 1'b0)
			tx_rdy[c] <= 1'b0;
		end
		`CHK(rd_pulses, exp_rd)
		`CHK(wr_pulses, exp_wr)
		// Each interrupt cause: raise, mask, then unmask and clear in the same cycle.
		for (k = 0; k < 4; k++)
		begin
			irq_ev <= 4'(1 << k);
			@(posedge clk);
			irq_ev <= 4'h0;
			repeat (2) @(posedge clk);
			`CHK(irq_stat, 4'(1 << k))
			`CHK(int_oe_n, 1'b0)
			`CHK(int_o, 1'b0)
			irq_mask <= 4'(1 << k);
			repeat (2) @(posedge clk);
			`CHK(int_oe_n, 1'b1)
			irq_mask <= 4'h0;
			irq_clr <= 4'(1 << k);
			@(posedge clk);
			irq_clr <= 4'h0;
			repeat (2) @(posedge clk);
			`CHK(int_oe_n, 1'b1)
			`CHK(irq_stat, 4'h0)
		end
		// A pending cause hit by a new event and its clear in one cycle stays set.
		irq_ev <= 4'h2;
		@(posedge clk);
		irq_clr <= 4'h2;
		@(posedge clk);
		irq_ev <= 4'h0;
		irq_clr <= 4'h0;
		repeat (2) @(posedge clk);
		`CHK(irq_stat, 4'h2)
		`CHK(int_oe_n, 1'b0)
		irq_clr <= 4'h2;
		@(posedge clk);
		irq_clr <= 4'h0;
		repeat (2) @(posedge clk);
		`CHK(int_oe_n, 1'b1)
		// Every clock mode with random pin levels; auto-start bits random, both set in mode 0.
		for (m = 0; m < 8; m++)
		begin
			r = rnd();
			md = 3'(m);
			mode <= {md, md};
			alt_in <= r[1:0];
			auto_st <= (m == 0) ? 2'h3 : r[3:2];
			repeat (5) @(posedge clk);
			for (c = 0; c < 2; c++)
			begin
				lv = (c == 0 && xtal(md)) ? 1'b0 : r[c];
				`CHK(alt_lvl[c], lv)
				`CHK(rx_en[c], ~auto_st[c] | lv)
				`CHK(rx_stb[c], (md == hdiap_pkg::CM_STROBE) ? lv : 1'b0)
			end
			`CHK(osc_a, xtal(md))
		end
		// A rising pin gives one sync pulse per channel in mode 5 and none in mode 0.
		for (k = 0; k < 2; k++)
		begin
			md = k ? 3'h0 : hdiap_pkg::CM_FSYNC;
			mode <= {md, md};
			alt_in <= 2'h0;
			repeat (5) @(posedge clk);
			alt_in <= 2'h3;
			n = 0;
			repeat (8)
			begin
				@(posedge clk);
				n += int'(fsync[0] === 1'b1) + int'(fsync[1] === 1'b1);
			end
			`CHK(n, k ? 0 : 2)
		end
		final_report();
	end

	// Watchdog against a hang anywhere in the sequence.
	initial
	begin
		repeat (20000) @(posedge clk);
		give_up();
	end
endmodule
